/* rtl/bpc_oc_timer.sv */
// Purpose: overcurrent delay and release timer, counting second ticks
// Assumes: tick is a one-cycle pulse once a second
// Notes:   a zero delay trips on the first tick while over the limit
`timescale 1ns/100ps
module bpc_oc_timer
  import bpc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        tick,
  input  wire logic        over,
  input  wire logic [15:0] delay_s,
  input  wire logic [15:0] release_s,
  output logic             tripped
);
  logic [15:0] cnt_ff;
  logic        trip_ff;
  wire  logic  dly_done = (cnt_ff >= delay_s);
  wire  logic  rel_done = (cnt_ff >= release_s);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_ff  <= 16'h0000;
      trip_ff <= 1'b0;
    end else if (!trip_ff) begin
      if (!over) begin
        cnt_ff <= 16'h0000;
      end else if (tick && dly_done) begin
        trip_ff <= 1'b1;
        cnt_ff  <= 16'h0000;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end else if (tick) begin
      if (rel_done) begin
        trip_ff <= 1'b0;
        cnt_ff  <= 16'h0000;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  assign tripped = trip_ff;
endmodule // bpc_oc_timer

/* rtl/bpc_pkg.sv */
// Purpose: shared constants for the battery protection controller
// Assumes: cell voltages in mV, currents in units of 0.1 A
// Notes:   register indices are word addresses on the plain register port
package bpc_pkg;
  localparam int          BPC_CELLS      = 8;
  localparam int          BPC_VW         = 16;
  localparam int          BPC_IW         = 16;
  localparam int          BPC_AW         = 4;
  localparam int          BPC_DW         = 32;
  // one second tick from the 100 MHz clock
  localparam int          BPC_CLK_HZ     = 100000000;
  localparam int          BPC_TICK_CYC   = BPC_CLK_HZ;
  // register word indices
  localparam logic [3:0]  BPC_REG_CTRL   = 4'h0;
  localparam logic [3:0]  BPC_REG_BALDIF = 4'h1;
  localparam logic [3:0]  BPC_REG_BALCUR = 4'h2;
  localparam logic [3:0]  BPC_REG_OVC    = 4'h3;
  localparam logic [3:0]  BPC_REG_UVC    = 4'h4;
  localparam logic [3:0]  BPC_REG_SDV    = 4'h5;
  localparam logic [3:0]  BPC_REG_CHGI   = 4'h6;
  localparam logic [3:0]  BPC_REG_DSGI   = 4'h7;
  localparam logic [3:0]  BPC_REG_CHGT   = 4'h8;
  localparam logic [3:0]  BPC_REG_DSGT   = 4'h9;
  localparam logic [3:0]  BPC_REG_STAT   = 4'ha;
  // control fields
  localparam int          BPC_C_BAL      = 0;
  localparam int          BPC_C_HEAT     = 1;
  localparam int          BPC_C_NOLIM    = 2;
  localparam int          BPC_C_IGN      = 3;
  localparam int          BPC_C_CHGDET   = 4;
  // status fields
  localparam int          BPC_S_OV       = 0;
  localparam int          BPC_S_UV       = 1;
  localparam int          BPC_S_COC      = 2;
  localparam int          BPC_S_DOC      = 3;
  localparam int          BPC_S_CHG      = 4;
  localparam int          BPC_S_DSG      = 5;
  localparam int          BPC_S_BAL      = 6;
  localparam int          BPC_S_OFF      = 7;
  // reset values and caps
  localparam logic [4:0]  BPC_CTRL_RST   = 5'h01;
  localparam logic [15:0] BPC_BALDIF_RST = 16'h000a;
  localparam logic [15:0] BPC_BALCUR_MAX = 16'h0014;
  localparam logic [15:0] BPC_OVP_RST    = 16'h0e42;
  localparam logic [15:0] BPC_OVR_RST    = 16'h0d48;
  localparam logic [15:0] BPC_UVP_RST    = 16'h0a8c;
  localparam logic [15:0] BPC_UVR_RST    = 16'h0bb8;
  localparam logic [15:0] BPC_SDV_RST    = 16'h09c4;
  localparam logic [15:0] BPC_CHGI_RST   = 16'h0640;
  localparam logic [15:0] BPC_DSGI_MAX   = 16'h07d0;
  localparam logic [15:0] BPC_DSGI_RST   = 16'h07d0;
  localparam logic [15:0] BPC_DLY_RST    = 16'h0005;
  localparam logic [15:0] BPC_REL_RST    = 16'h003c;
endpackage : bpc_pkg

/* rtl/bpc_top.sv */
// Purpose: protection and balancing controller for a series cell pack
// Assumes: cell voltages and currents sampled synchronously to ref_clk
// Notes:   registers are word-indexed; read data valid one cycle later
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module bpc_top
  import bpc_pkg::*;
#(
  parameter int CELLS    = BPC_CELLS,
  parameter int TICK_CYC = BPC_TICK_CYC,
  parameter logic [15:0] BAL_MAX = BPC_BALCUR_MAX
)(
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic [CELLS*BPC_VW-1:0] cell_mv,
  input  wire logic [BPC_IW-1:0]      chg_current,
  input  wire logic [BPC_IW-1:0]      dsg_current,
  input  wire logic                   charging,
  input  wire logic                   discharging,
  input  wire logic                   over_temp,
  input  wire logic                   ignition_sense_pos,
  input  wire logic                   ignition_sense_neg,
  input  wire logic                   charger_sense,
  input  wire logic [BPC_AW-1:0]      reg_addr,
  input  wire logic [BPC_DW-1:0]      reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [BPC_DW-1:0]           reg_rdata,
  output logic                        chg_en,
  output logic                        dsg_en,
  output logic                        bal_on,
  output logic [15:0]                 bal_current,
  output logic                        heater_on,
  output logic                        alarm,
  output logic                        power_off
);
  // ==========================================================
  // configuration registers
  logic [4:0]    ctrl_ff;
  logic [15:0]   baldif_ff;
  logic [15:0]   balcur_ff;
  logic [15:0]   ovp_ff;
  logic [15:0]   ovr_ff;
  logic [15:0]   uvp_ff;
  logic [15:0]   uvr_ff;
  logic [15:0]   sdv_ff;
  logic [15:0]   chgi_ff;
  logic [15:0]   dsgi_ff;
  logic [15:0]   cdly_ff;
  logic [15:0]   crel_ff;
  logic [15:0]   ddly_ff;
  logic [15:0]   drel_ff;
  logic [BPC_DW-1:0] rdata_ff;

  wire logic [15:0] wd_lo = reg_wdata[15:0];
  wire logic [15:0] wd_hi = reg_wdata[31:16];
  wire logic [15:0] nxt_dsgi = (wd_lo > BPC_DSGI_MAX) ? BPC_DSGI_MAX : wd_lo;
  wire logic w_ctrl   = reg_wr && (reg_addr == BPC_REG_CTRL);
  wire logic w_baldif = reg_wr && (reg_addr == BPC_REG_BALDIF);
  wire logic w_balcur = reg_wr && (reg_addr == BPC_REG_BALCUR);
  wire logic w_ovc    = reg_wr && (reg_addr == BPC_REG_OVC);
  wire logic w_uvc    = reg_wr && (reg_addr == BPC_REG_UVC);
  wire logic w_sdv    = reg_wr && (reg_addr == BPC_REG_SDV);
  wire logic w_chgi   = reg_wr && (reg_addr == BPC_REG_CHGI);
  wire logic w_dsgi   = reg_wr && (reg_addr == BPC_REG_DSGI);
  wire logic w_chgt   = reg_wr && (reg_addr == BPC_REG_CHGT);
  wire logic w_dsgt   = reg_wr && (reg_addr == BPC_REG_DSGT);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_ff   <= BPC_CTRL_RST;
      baldif_ff <= BPC_BALDIF_RST;
      balcur_ff <= BAL_MAX;
      ovp_ff    <= BPC_OVP_RST;
      ovr_ff    <= BPC_OVR_RST;
      uvp_ff    <= BPC_UVP_RST;
      uvr_ff    <= BPC_UVR_RST;
      sdv_ff    <= BPC_SDV_RST;
      chgi_ff   <= BPC_CHGI_RST;
      dsgi_ff   <= BPC_DSGI_RST;
      cdly_ff   <= BPC_DLY_RST;
      crel_ff   <= BPC_REL_RST;
      ddly_ff   <= BPC_DLY_RST;
      drel_ff   <= BPC_REL_RST;
    end else begin
      if (w_ctrl) ctrl_ff <= reg_wdata[4:0];
      if (w_baldif) baldif_ff <= wd_lo;
      if (w_balcur) balcur_ff <= (wd_lo > BAL_MAX) ? BAL_MAX : wd_lo;
      if (w_ovc) begin
        ovp_ff <= wd_lo;
        ovr_ff <= wd_hi;
      end
      if (w_uvc) begin
        uvp_ff <= wd_lo;
        uvr_ff <= wd_hi;
      end
      if (w_sdv) sdv_ff <= wd_lo;
      if (w_chgi) chgi_ff <= wd_lo;
      if (w_dsgi) dsgi_ff <= nxt_dsgi;
      if (w_chgt) begin
        cdly_ff <= wd_lo;
        crel_ff <= wd_hi;
      end
      if (w_dsgt) begin
        ddly_ff <= wd_lo;
        drel_ff <= wd_hi;
      end
    end
  end

  // ==========================================================
  // cell comparisons, one generate loop over the cells
  logic [CELLS-1:0] c_ov;
  logic [CELLS-1:0] c_ovr;
  logic [CELLS-1:0] c_uv;
  logic [CELLS-1:0] c_uvr;
  logic [CELLS-1:0] c_sd;
  logic [BPC_VW-1:0] vmax [CELLS];
  logic [BPC_VW-1:0] vmin [CELLS];

  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++) begin : g_cell
      wire logic [BPC_VW-1:0] v = cell_mv[gi*BPC_VW +: BPC_VW];
      assign c_ov[gi]  = (v > ovp_ff);
      assign c_ovr[gi] = (v < ovr_ff);
      assign c_uv[gi]  = (v < uvp_ff);
      assign c_uvr[gi] = (v > uvr_ff);
      assign c_sd[gi]  = (v < sdv_ff);
      if (gi == 0) begin : g_first
        assign vmax[gi] = v;
        assign vmin[gi] = v;
      end else begin : g_next
        assign vmax[gi] = (v > vmax[gi-1]) ? v : vmax[gi-1];
        assign vmin[gi] = (v < vmin[gi-1]) ? v : vmin[gi-1];
      end
    end
  endgenerate

  wire logic [BPC_VW-1:0] spread = vmax[CELLS-1] - vmin[CELLS-1];

  // ==========================================================
  // one-second tick; long count kept as a parameter
  logic [31:0] div_ff;
  wire  logic  tick = (div_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) div_ff <= 32'h00000000;
    else if (tick) div_ff <= 32'h00000000;
    else div_ff <= div_ff + 32'h00000001;
  end

  // ==========================================================
  // voltage trip flags
  logic ov_ff;
  logic uv_ff;
  logic off_ff;
  logic bal_ff;
  logic heat_ff;
  logic alarm_ff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ov_ff  <= 1'b0;
      uv_ff  <= 1'b0;
      off_ff <= 1'b0;
    end else begin
      if (charging && |c_ov) ov_ff <= 1'b1;
      else if (&c_ovr) ov_ff <= 1'b0;
      if (discharging && |c_uv) uv_ff <= 1'b1;
      else if (&c_uvr) uv_ff <= 1'b0;
      if (|c_sd) off_ff <= 1'b1;
    end
  end

  // ==========================================================
  // current trips
  logic coc;
  logic doc;
  // limit-disable bit suppresses charge current trip
  wire logic chg_over = (chg_current > chgi_ff) && !ctrl_ff[BPC_C_NOLIM];
  wire logic dsg_over = (dsg_current > dsgi_ff);

  bpc_oc_timer u_chg_oc (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .tick      (tick),
    .over      (chg_over),
    .delay_s   (cdly_ff),
    .release_s (crel_ff),
    .tripped   (coc)
  );

  bpc_oc_timer u_dsg_oc (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .tick      (tick),
    .over      (dsg_over),
    .delay_s   (ddly_ff),
    .release_s (drel_ff),
    .tripped   (doc)
  );

  // ==========================================================
  // path enables and auxiliary outputs
  // ignition sense active by voltage or short
  wire logic ign_ok  = !ctrl_ff[BPC_C_IGN] ||
                       (ignition_sense_pos ^ ignition_sense_neg) ||
                       (ignition_sense_pos & ignition_sense_neg);
  wire logic chg_ok  = !ctrl_ff[BPC_C_CHGDET] || charger_sense;
  // enables are AND of untripped conditions and the ignition or charger sense check
  wire logic nxt_chg = !ov_ff && !coc && chg_ok && !off_ff;
  wire logic nxt_dsg = !uv_ff && !doc && ign_ok && !off_ff;
  wire logic nxt_bal = ctrl_ff[BPC_C_BAL] && (spread > baldif_ff) && !off_ff;
  wire logic nxt_alarm = over_temp || ov_ff || uv_ff;
  logic chg_ff;
  logic dsg_ff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      chg_ff   <= 1'b0;
      dsg_ff   <= 1'b0;
      bal_ff   <= 1'b0;
      heat_ff  <= 1'b0;
      alarm_ff <= 1'b0;
    end else begin
      chg_ff   <= nxt_chg;
      dsg_ff   <= nxt_dsg;
      bal_ff   <= nxt_bal;
      heat_ff  <= ctrl_ff[BPC_C_HEAT];
      alarm_ff <= nxt_alarm;
    end
  end

  // ==========================================================
  // read path; unmapped indices read zero
  logic [7:0] stat;
  assign stat[BPC_S_OV]  = ov_ff;
  assign stat[BPC_S_UV]  = uv_ff;
  assign stat[BPC_S_COC] = coc;
  assign stat[BPC_S_DOC] = doc;
  assign stat[BPC_S_CHG] = chg_ff;
  assign stat[BPC_S_DSG] = dsg_ff;
  assign stat[BPC_S_BAL] = bal_ff;
  assign stat[BPC_S_OFF] = off_ff;

  logic [BPC_DW-1:0] rmux;
  always_comb begin
    unique case (reg_addr)
      BPC_REG_CTRL:   rmux = {27'h0, ctrl_ff};
      BPC_REG_BALDIF: rmux = {16'h0, baldif_ff};
      BPC_REG_BALCUR: rmux = {16'h0, balcur_ff};
      BPC_REG_OVC:    rmux = {ovr_ff, ovp_ff};
      BPC_REG_UVC:    rmux = {uvr_ff, uvp_ff};
      BPC_REG_SDV:    rmux = {16'h0, sdv_ff};
      BPC_REG_CHGI:   rmux = {16'h0, chgi_ff};
      BPC_REG_DSGI:   rmux = {16'h0, dsgi_ff};
      BPC_REG_CHGT:   rmux = {crel_ff, cdly_ff};
      BPC_REG_DSGT:   rmux = {drel_ff, ddly_ff};
      BPC_REG_STAT:   rmux = {24'h0, stat};
      default:        rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) rdata_ff <= 32'h00000000;
    else if (reg_rd) rdata_ff <= rmux;
    else rdata_ff <= 32'h00000000;
  end

  assign reg_rdata   = rdata_ff;
  assign chg_en      = chg_ff;
  assign dsg_en      = dsg_ff;
  assign bal_on      = bal_ff;
  assign bal_current = balcur_ff;
  assign heater_on   = heat_ff;
  assign alarm       = alarm_ff;
  assign power_off   = off_ff;
endmodule // bpc_top

/* verification/bpc_pack_model.sv */
// Purpose: cell string and power switch stand-in
// Assumes: charger and load always present behind the switches
// Notes:   only cell 0 is steered; the rest sit at BASE_MV
`timescale 1ns/100ps
module bpc_pack_model
  import bpc_pkg::*;
#(parameter int CELLS = BPC_CELLS,
  parameter logic [15:0] BASE_MV = 16'h0ce4)(
  input  wire logic [15:0]          odd_mv,
  input  wire logic [15:0]          chg_load,
  input  wire logic [15:0]          dsg_load,
  input  wire logic                 chg_en,
  input  wire logic                 dsg_en,
  output logic [CELLS*BPC_VW-1:0]   cell_mv,
  output logic [15:0]               chg_current,
  output logic [15:0]               dsg_current,
  output logic                      charging,
  output logic                      discharging
);
  // an open switch carries no current, so a trip clears its own cause
  assign charging    = chg_en;
  assign discharging = dsg_en;
  assign chg_current = chg_en ? chg_load : 16'h0000;
  assign dsg_current = dsg_en ? dsg_load : 16'h0000;
  assign cell_mv     = {{(CELLS-1){BASE_MV}}, odd_mv};
endmodule // bpc_pack_model

/* verification/bpc_top_assertions.sv */
// Purpose: port assertions for the protection controller
// Assumes: outputs are registers one cycle behind causes
// Notes:   keeps its own copy of the control word
`timescale 1ns/100ps
module bpc_top_assertions
  import bpc_pkg::*;
#(parameter logic [15:0] BAL_MAX = BPC_BALCUR_MAX)(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        over_temp,
  input wire logic        ignition_sense_pos,
  input wire logic        ignition_sense_neg,
  input wire logic        charger_sense,
  input wire logic        chg_en,
  input wire logic        dsg_en,
  input wire logic        bal_on,
  input wire logic [15:0] bal_current,
  input wire logic        heater_on,
  input wire logic        alarm,
  input wire logic        power_off
);
  // ==========================================
  // control copy, rebuilt from bus writes
  logic [4:0] ctrl_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      ctrl_ff <= BPC_CTRL_RST;
    else if (reg_wr && reg_addr == BPC_REG_CTRL)
      ctrl_ff <= reg_wdata[4:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // properties
  property p_bal_off; !ctrl_ff[BPC_C_BAL] |=> !bal_on; endproperty
  a_bal_off: assert property (p_bal_off)
    else $error("balancing while disabled");
  property p_bal_cap; bal_current <= BAL_MAX; endproperty
  a_bal_cap: assert property (p_bal_cap)
    else $error("balance current above board maximum");
  property p_heat;
    1'b1 |=> heater_on == $past(ctrl_ff[BPC_C_HEAT]);
  endproperty
  a_heat: assert property (p_heat)
    else $error("heater does not follow its setting");
  property p_alarm; over_temp |=> alarm; endproperty
  a_alarm: assert property (p_alarm)
    else $error("no alarm on overtemperature");
  property p_ign;
    ctrl_ff[BPC_C_IGN] && !ignition_sense_pos && !ignition_sense_neg
      |=> !dsg_en;
  endproperty
  a_ign: assert property (p_ign)
    else $error("discharge without ignition sense");
  property p_chgdet;
    ctrl_ff[BPC_C_CHGDET] && !charger_sense |=> !chg_en;
  endproperty
  a_chgdet: assert property (p_chgdet)
    else $error("charge without charger sense");
  // latched until reset: a bounced shutdown would chatter the pack
  property p_off; power_off |=> power_off; endproperty
  a_off: assert property (p_off)
    else $error("shutdown released without reset");
  property p_dsgi;
    reg_rd && reg_addr == BPC_REG_DSGI |=> reg_rdata[15:0] <= BPC_DSGI_MAX;
  endproperty
  a_dsgi: assert property (p_dsgi)
    else $error("discharge limit above cap");
  c_bal: cover property (bal_on);
  c_off: cover property (power_off);
  c_back: cover property (!chg_en ##1 chg_en);
endmodule // bpc_top_assertions

bind bpc_top bpc_top_assertions #(.BAL_MAX(BAL_MAX)) u_chk (
  .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .over_temp, .ignition_sense_pos, .ignition_sense_neg,
  .charger_sense, .chg_en, .dsg_en, .bal_on, .bal_current, .heater_on,
  .alarm, .power_off);

/* verification/tb_battery_protection_control.sv */
// Purpose: self-checking bench for the protection controller
// Assumes: second tick shortened to T cycles
// Notes:   trip timing is judged to within two ticks
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_battery_protection_control
  import bpc_pkg::*;
;
  localparam int T = 10;
  localparam logic [31:0] rst_tab [10] = '{
    {27'h0, BPC_CTRL_RST}, {16'h0, BPC_BALDIF_RST}, {16'h0, BPC_BALCUR_MAX},
    {BPC_OVR_RST, BPC_OVP_RST}, {BPC_UVR_RST, BPC_UVP_RST},
    {16'h0, BPC_SDV_RST}, {16'h0, BPC_CHGI_RST}, {16'h0, BPC_DSGI_RST},
    {BPC_REL_RST, BPC_DLY_RST}, {BPC_REL_RST, BPC_DLY_RST}};
  logic                        ref_clk, reset_n, reg_wr, reg_rd;
  logic [BPC_CELLS*BPC_VW-1:0] cell_mv;
  logic [15:0]                 odd_mv, chg_load, dsg_load, bal_current;
  logic [15:0]                 chg_current, dsg_current;
  logic [3:0]                  reg_addr;
  logic [31:0]                 reg_wdata, reg_rdata, rdat;
  logic                        charging, discharging, over_temp;
  logic                        ignition_sense_pos, ignition_sense_neg;
  logic                        charger_sense, chg_en, dsg_en, bal_on;
  logic                        heater_on, alarm, power_off;
  int                          n_errors, total_checks, cyc, n;
  wire  [5:0]                  out_vec = {alarm, heater_on, power_off,
                                          bal_on, dsg_en, chg_en};
  bpc_top #(.TICK_CYC(T)) u_dut (
    .ref_clk, .reset_n, .cell_mv, .chg_current, .dsg_current, .charging,
    .discharging, .over_temp, .ignition_sense_pos, .ignition_sense_neg,
    .charger_sense, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chg_en, .dsg_en, .bal_on, .bal_current, .heater_on, .alarm,
    .power_off);
  bpc_pack_model u_pack (
    .odd_mv, .chg_load, .dsg_load, .chg_en, .dsg_en, .cell_mv,
    .chg_current, .dsg_current, .charging, .discharging);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========================================
  // bus and wait helpers
  // strobe drops, then a free edge, so calls never collide
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic expect_lvl(input int s, input logic v, input int lim);
    n = 0;
    #1;
    while (out_vec[s] !== v && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(out_vec[s], v)
    @(posedge ref_clk);
  endtask
  task automatic set_cell(input logic [15:0] v);
    odd_mv <= v;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic load(input int s, input logic [15:0] v);
    if (s == 0) chg_load <= v;
    else dsg_load <= v;
  endtask
  task automatic oc_run(input int s);
    wr(s ? BPC_REG_DSGT : BPC_REG_CHGT, {16'h0004, 16'h0002});
    load(s, 16'h0800);
    expect_lvl(s, 1'b0, 4 * T);
    `CHK(n >= 2 * T, 1'b1)
    expect_lvl(s, 1'b1, 6 * T);
    `CHK(n >= 4 * T - 4, 1'b1)
    load(s, 16'h0010);
    @(posedge ref_clk);
    // short bursts with two full ticks under the limit between them
    repeat (3) begin
      load(s, 16'h0800);
      repeat (12) @(posedge ref_clk);
      load(s, 16'h0010);
      repeat (2 * T) @(posedge ref_clk);
      expect_lvl(s, 1'b1, 0);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 32'h0; odd_mv = 16'h0ce4;
    chg_load = 16'h0010; dsg_load = 16'h0010; over_temp = 1'b0;
    ignition_sense_pos = 1'b0; ignition_sense_neg = 1'b0;
    charger_sense = 1'b0; n_errors = 0; total_checks = 0; cyc = 0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], rdat);
      `CHK(rdat, rst_tab[i])
    end
    wr(BPC_REG_STAT, 32'h0000_00ff);
    rd(BPC_REG_STAT, rdat);
    `CHK(rdat, 32'h0000_0030)
    wr(4'hf, 32'h0000_0000);
    rd(4'hf, rdat);
    `CHK(rdat, 32'h0000_0000)
    wr(BPC_REG_DSGI, 32'h0000_0fff);
    rd(BPC_REG_DSGI, rdat);
    `CHK(rdat, 32'h0000_07d0)
    wr(BPC_REG_DSGI, 32'h0000_0100);
    wr(BPC_REG_BALCUR, 32'h0000_00ff);
    rd(BPC_REG_BALCUR, rdat);
    `CHK(bal_current, BPC_BALCUR_MAX)
    `CHK(rdat, {16'h0, BPC_BALCUR_MAX})
    wr(BPC_REG_BALCUR, 32'h0000_000a);
    rd(BPC_REG_BALCUR, rdat);
    `CHK(bal_current, 16'h000a)
    `CHK(rdat, 32'h0000_000a)
    $display("register test done");
    set_cell(16'h0cf3);
    expect_lvl(2, 1'b1, 3);
    set_cell(16'h0ce9);
    expect_lvl(2, 1'b0, 3);
    set_cell(16'h0cf3);
    wr(BPC_REG_CTRL, 32'h0000_0002);
    expect_lvl(2, 1'b0, 3);
    expect_lvl(4, 1'b1, 0);
    wr(BPC_REG_CTRL, 32'h0000_0001);
    expect_lvl(4, 1'b0, 0);
    expect_lvl(2, 1'b1, 3);
    wr(BPC_REG_CTRL, 32'h0000_0009);
    expect_lvl(1, 1'b0, 3);
    ignition_sense_neg <= 1'b1;
    expect_lvl(1, 1'b1, 3);
    ignition_sense_neg <= 1'b0;
    expect_lvl(1, 1'b0, 3);
    ignition_sense_pos <= 1'b1;
    expect_lvl(1, 1'b1, 3);
    ignition_sense_pos <= 1'b0;
    expect_lvl(1, 1'b0, 3);
    // shorted terminals read as both inputs high
    ignition_sense_pos <= 1'b1;
    ignition_sense_neg <= 1'b1;
    expect_lvl(1, 1'b1, 3);
    wr(BPC_REG_CTRL, 32'h0000_0011);
    expect_lvl(0, 1'b0, 3);
    charger_sense <= 1'b1;
    expect_lvl(0, 1'b1, 3);
    wr(BPC_REG_CTRL, 32'h0000_0001);
    over_temp <= 1'b1;
    expect_lvl(5, 1'b1, 3);
    over_temp <= 1'b0;
    expect_lvl(5, 1'b0, 3);
    $display("control test done");
    set_cell(16'h0e43);
    expect_lvl(0, 1'b0, 3);
    expect_lvl(5, 1'b1, 0);
    set_cell(16'h0dac);
    expect_lvl(0, 1'b0, 0);
    rd(BPC_REG_STAT, rdat);
    `CHK(rdat[BPC_S_OV], 1'b1)
    set_cell(16'h0d47);
    expect_lvl(0, 1'b1, 3);
    set_cell(16'h0a8b);
    expect_lvl(1, 1'b0, 3);
    expect_lvl(5, 1'b1, 0);
    set_cell(16'h0b54);
    expect_lvl(1, 1'b0, 0);
    set_cell(16'h0bb9);
    expect_lvl(1, 1'b1, 3);
    $display("voltage test done");
    for (int s = 0; s < 2; s++) oc_run(s);
    wr(BPC_REG_CTRL, 32'h0000_0005);
    load(0, 16'h0800);
    repeat (5 * T) @(posedge ref_clk);
    expect_lvl(0, 1'b1, 0);
    load(0, 16'h0010);
    wr(BPC_REG_CTRL, 32'h0000_0001);
    $display("overcurrent test done");
    set_cell(16'h09c3);
    expect_lvl(3, 1'b1, 3);
    set_cell(16'h0ce4);
    expect_lvl(3, 1'b1, 0);
    // only a reset lifts the shutdown latch
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    expect_lvl(3, 1'b0, 2);
    `CHK(bal_current, BPC_BALCUR_MAX)
    expect_lvl(0, 1'b1, 2);
    $display("shutdown test done");
    stop_test();
  end
endmodule // tb_battery_protection_control
